/* File: inc/rxc_pkg.sv */
// types shared by the receiver config bank
package rxc_pkg;
  typedef enum logic [1:0] {
    RXC_SRC_IDLE,
    RXC_SRC_ANALOG,
    RXC_SRC_ENVELOPE,
    RXC_SRC_GENERIC
  } rxc_src_e;

  typedef enum logic [1:0] {
    RXC_EMD_IDLE,
    RXC_EMD_HOLD,
    RXC_EMD_PASS
  } rxc_emd_e;

  // settings for the analog front end and bit decoder
  typedef struct packed {
    logic quasi_diff;
    logic low_power_card_detect_mode;
    rxc_src_e src;
    logic [1:0] coll_thr;
    logic coll_en;
    logic [1:0] hpcf;
    logic [1:0] gain;
    logic [3:0] dec_min;
    logic [3:0] phase_min;
  } rxc_afe_s;

  // settings for the receive framer
  typedef struct packed {
    logic allow_partial;
    logic multi;
    logic eof_type_b;
    logic eof_check_en;
    logic guard_check;
    logic suppress;
    logic [2:0] rate;
    logic rate_valid;
  } rxc_frm_s;
endpackage : rxc_pkg

/* File: inc/rxcfg_params.svh */
// offsets, field positions, reset values and timing counts of the receiver config bank
`ifndef RXCFG_PARAMS_SVH
`define RXCFG_PARAMS_SVH

// register offsets
`define RXC_ADDR_CTRL 8'h35
`define RXC_ADDR_HOLD 8'h36
`define RXC_ADDR_THR 8'h37
`define RXC_ADDR_FE 8'h38
`define RXC_ADDR_ANA 8'h39

// reset values
`define RXC_RST_CTRL 8'h04
`define RXC_RST_HOLD 8'h00
`define RXC_RST_THR 8'h00
`define RXC_RST_FE 8'h10
`define RXC_RST_ANA 8'h00

// receive_control fields
`define RXC_B_ALLOW 7
`define RXC_B_MULTI 6
`define RXC_B_EOFT 5
`define RXC_B_GUARD 4
`define RXC_B_SUPP 3

// writable bits of the mixed registers
`define RXC_FE_WMASK 8'hF3
`define RXC_ANA_WMASK 8'hCF

// timing
`define RXC_CLK_NS 40
`define RXC_CARRIER_UNIT_NS 1180
`define RXC_CARRIER_UNIT_CYC ((`RXC_CARRIER_UNIT_NS + `RXC_CLK_NS - 1) / `RXC_CLK_NS)
`define RXC_HALFBIT_847_NS 590
`define RXC_HALFBIT_847_CYC ((`RXC_HALFBIT_847_NS + `RXC_CLK_NS - 1) / `RXC_CLK_NS)
`define RXC_EMD_BYTES 3

`endif

/* File: rtl/rxc_emd.sv */
// disturbance filter over the first received bytes of a frame
`include "rxcfg_params.svh"
module rxc_emd (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // framer events
  input wire logic i_en,
  input wire logic i_sof,
  input wire logic i_byte,
  input wire logic i_err,
  input wire logic i_frame_end,
  // results
  output logic o_fifo_flush,
  output logic o_rx_done
);
  rxc_pkg::rxc_emd_e state_reg;
  logic [1:0] cnt_reg;

  // the error wins over a byte in the same cycle: the byte is part of the disturbance
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= rxc_pkg::RXC_EMD_IDLE;
      cnt_reg <= 2'h0;
      o_fifo_flush <= 1'b0;
      o_rx_done <= 1'b0;
    end
    else
    begin
      o_fifo_flush <= 1'b0;
      o_rx_done <= 1'b0;
      case (state_reg)
        rxc_pkg::RXC_EMD_IDLE:
        begin
          cnt_reg <= 2'h0;
          if (i_sof)
            state_reg <= rxc_pkg::RXC_EMD_HOLD;
        end
        rxc_pkg::RXC_EMD_HOLD:
        begin
          if (i_en && i_err)
          begin
            o_fifo_flush <= 1'b1;
            state_reg <= rxc_pkg::RXC_EMD_IDLE;
          end
          else if (i_frame_end)
          begin
            o_fifo_flush <= i_en;
            o_rx_done <= !i_en;
            state_reg <= rxc_pkg::RXC_EMD_IDLE;
          end
          else if (i_byte)
          begin
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == 2'(`RXC_EMD_BYTES - 1))
              state_reg <= rxc_pkg::RXC_EMD_PASS;
          end
        end
        rxc_pkg::RXC_EMD_PASS:
        begin
          if (i_frame_end)
          begin
            o_rx_done <= 1'b1;
            state_reg <= rxc_pkg::RXC_EMD_IDLE;
          end
        end
        default:
          state_reg <= rxc_pkg::RXC_EMD_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  emd_short_a: assert property (i_en && state_reg == rxc_pkg::RXC_EMD_HOLD && !i_err
    && i_frame_end |=> o_fifo_flush && !o_rx_done)
    else $error("short frame not treated as disturbance");
  emd_err_a: assert property (i_en && state_reg == rxc_pkg::RXC_EMD_HOLD && i_err
    |=> o_fifo_flush)
    else $error("early error did not flush");
endmodule : rxc_emd

/* File: rtl/rxc_holdoff.sv */
// hold-off timer that blanks the receiver after a transmission
`include "rxcfg_params.svh"
module rxc_holdoff (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_start,
  input wire logic i_unit_sel,
  input wire logic [6:0] i_count,
  input wire logic [2:0] i_rate,
  // status
  output logic o_ignore
);
  logic [9:0] unit_cyc;
  logic [2:0] rate_eff;
  logic [9:0] pre_reg;
  logic [6:0] left_reg;

  // reserved tx rate codes fall back to 106 kBd so the unit never becomes huge
  assign rate_eff = (i_rate < 3'h2) ? 3'h4 : i_rate;
  // half a bit period doubles for each step below the top rate
  assign unit_cyc = i_unit_sel ?
    (10'(`RXC_HALFBIT_847_CYC) << (3'h7 - rate_eff)) :
    10'(`RXC_CARRIER_UNIT_CYC);

  // count units down; the unit size is sampled live, a change mid-wait shifts the end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pre_reg <= 10'h000;
      left_reg <= 7'h00;
      o_ignore <= 1'b0;
    end
    else if (i_start)
    begin
      pre_reg <= unit_cyc - 10'h001;
      left_reg <= i_count;
      o_ignore <= (i_count != 7'h00);
    end
    else if (o_ignore)
    begin
      if (pre_reg != 10'h000)
        pre_reg <= pre_reg - 10'h001;
      else
      begin
        pre_reg <= unit_cyc - 10'h001;
        left_reg <= left_reg - 7'h01;
        if (left_reg == 7'h01)
          o_ignore <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  hold_start_a: assert property (i_start && i_count != 7'h00 |=> o_ignore)
    else $error("hold-off did not start");
  hold_carrier_a: assert property (i_start && i_count == 7'h01 && !i_unit_sel
    |=> o_ignore [*8])
    else $error("carrier-unit hold-off ended early");
endmodule : rxc_holdoff

/* File: rtl/rxc_regs.sv */
// receiver configuration register bank with hold-off, guard and disturbance logic
//
// The address-and-strobe port is this design's own decision.
`include "rxcfg_params.svh"
// How it works
// - allow flag writes incomplete last byte
// - multi-frame flag keeps receiver running
// - multi-frame appends error register copy
// - end type bit picks frame end
// - type zero, no symbols: skip check
// - type B guard too long: protocol error
// - early error or collision flushes FIFO
// - short frame is disturbance, no done
// - rate field codes 2h-7h, others reserved
// - hold-off unit carrier or half bit
// - ignore input for hold-off after transmit
// - threshold nibbles feed decoder and phase
// - bit 7 picks differential input mode
// - bit 6 selects card detection mode
// - two-bit field routes signal source
// - collision threshold codes, 3h disables
// - tuning drives high-pass and gain
// - half-bit unit uses transmit rate
module rxc_regs #(
  parameter logic [9:0] EGT_MAX_CYC = 10'h032
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // transmitter status
  input wire logic I_TX_END,
  input wire logic [2:0] I_TX_RATE,
  // framer events
  input wire logic I_RX_SOF,
  input wire logic I_RX_BYTE,
  input wire logic I_RX_ERR,
  input wire logic I_RX_FRAME_END,
  input wire logic I_LAST_PARTIAL,
  input wire logic I_CRC_EN,
  input wire logic [7:0] I_ERROR_REG,
  input wire logic [1:0] I_EOF_SYM,
  input wire logic I_TYPE_B,
  input wire logic I_EGT_ACTIVE,
  // settings out
  output rxc_pkg::rxc_frm_s O_FRM,
  output rxc_pkg::rxc_afe_s O_AFE,
  // receive control out
  output logic O_RX_IGNORE,
  output logic O_PARTIAL_WRITE,
  output logic O_ERR_BYTE_PUSH,
  output logic [7:0] O_ERR_BYTE,
  output logic O_FIFO_FLUSH,
  output logic O_RX_DONE,
  output logic O_PROTOCOL_ERR
);
  logic [7:0] ctrl_reg;
  logic [7:0] hold_reg;
  logic [7:0] thr_reg;
  logic [7:0] fe_reg;
  logic [7:0] ana_reg;
  logic [7:0] rdata_next;
  logic [9:0] egt_cnt_reg;
  logic egt_done_reg;
  logic guard_on;
  logic wr_ctrl;
  logic wr_hold;
  logic wr_thr;
  logic wr_fe;
  logic wr_ana;

  // address decode
  assign wr_ctrl = I_WR && (I_ADDR == `RXC_ADDR_CTRL);
  assign wr_hold = I_WR && (I_ADDR == `RXC_ADDR_HOLD);
  assign wr_thr = I_WR && (I_ADDR == `RXC_ADDR_THR);
  assign wr_fe = I_WR && (I_ADDR == `RXC_ADDR_FE);
  assign wr_ana = I_WR && (I_ADDR == `RXC_ADDR_ANA);

  // receive_control
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      ctrl_reg <= `RXC_RST_CTRL;
    else if (wr_ctrl)
      ctrl_reg <= I_WDATA;
  end

  // receive_holdoff
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      hold_reg <= `RXC_RST_HOLD;
    else if (wr_hold)
      hold_reg <= I_WDATA;
  end

  // decoder_threshold
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      thr_reg <= `RXC_RST_THR;
    else if (wr_thr)
      thr_reg <= I_WDATA;
  end

  // front-end select; reserved bits never store, so they cannot leak anywhere
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      fe_reg <= `RXC_RST_FE;
    else if (wr_fe)
      fe_reg <= I_WDATA & `RXC_FE_WMASK;
  end

  // analog tuning; bits 5:4 never store and read zero, bits 7:6 stored as written
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      ana_reg <= `RXC_RST_ANA;
    else if (wr_ana)
      ana_reg <= I_WDATA & `RXC_ANA_WMASK;
  end

  // read mux; unmapped addresses answer zero
  always_comb
  begin
    case (I_ADDR)
      `RXC_ADDR_CTRL: rdata_next = ctrl_reg;
      `RXC_ADDR_HOLD: rdata_next = hold_reg;
      `RXC_ADDR_THR: rdata_next = thr_reg;
      `RXC_ADDR_FE: rdata_next = fe_reg;
      `RXC_ADDR_ANA: rdata_next = ana_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      O_RDATA <= 8'h00;
    else if (I_RD)
      O_RDATA <= rdata_next;
    else
      O_RDATA <= 8'h00;
  end

  // front-end settings come straight from the register flops; one process drives the struct
  always_comb
  begin
    O_AFE.quasi_diff = fe_reg[7];
    O_AFE.low_power_card_detect_mode = fe_reg[6];
    O_AFE.src = rxc_pkg::rxc_src_e'(fe_reg[5:4]);
    O_AFE.coll_thr = fe_reg[1:0];
    O_AFE.coll_en = ~&fe_reg[1:0];
    O_AFE.hpcf = ana_reg[3:2];
    O_AFE.gain = ana_reg[1:0];
    O_AFE.dec_min = thr_reg[7:4];
    O_AFE.phase_min = thr_reg[3:0];
  end

  // framer settings; end-symbol config is an input, so the check enable is re-timed
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      O_FRM <= '0;
    else
    begin
      O_FRM.allow_partial <= ctrl_reg[`RXC_B_ALLOW];
      O_FRM.multi <= ctrl_reg[`RXC_B_MULTI];
      O_FRM.eof_type_b <= ctrl_reg[`RXC_B_EOFT];
      O_FRM.eof_check_en <= ctrl_reg[`RXC_B_EOFT] || (I_EOF_SYM != 2'h0);
      O_FRM.guard_check <= ctrl_reg[`RXC_B_GUARD];
      O_FRM.suppress <= ctrl_reg[`RXC_B_SUPP];
      O_FRM.rate <= ctrl_reg[2:0];
      O_FRM.rate_valid <= (ctrl_reg[2:0] >= 3'h2);
    end
  end

  // incomplete last byte goes to the FIFO when allowed or when no checksum guards it
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      O_PARTIAL_WRITE <= 1'b0;
    else
      O_PARTIAL_WRITE <= I_RX_FRAME_END && I_LAST_PARTIAL
        && (ctrl_reg[`RXC_B_ALLOW] || !I_CRC_EN);
  end

  // error byte snapshot at the end of each stream in multi-frame mode
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_ERR_BYTE_PUSH <= 1'b0;
      O_ERR_BYTE <= 8'h00;
    end
    else
    begin
      O_ERR_BYTE_PUSH <= I_RX_FRAME_END && ctrl_reg[`RXC_B_MULTI];
      if (I_RX_FRAME_END && ctrl_reg[`RXC_B_MULTI])
        O_ERR_BYTE <= I_ERROR_REG;
    end
  end

  // guard time measure; only one error per guard gap, the counter saturates
  assign guard_on = ctrl_reg[`RXC_B_GUARD] && I_TYPE_B && I_EGT_ACTIVE;
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      egt_cnt_reg <= 10'h000;
      egt_done_reg <= 1'b0;
      O_PROTOCOL_ERR <= 1'b0;
    end
    else if (!guard_on)
    begin
      egt_cnt_reg <= 10'h000;
      egt_done_reg <= 1'b0;
      O_PROTOCOL_ERR <= 1'b0;
    end
    else
    begin
      if (!egt_done_reg)
        egt_cnt_reg <= egt_cnt_reg + 10'h001;
      O_PROTOCOL_ERR <= !egt_done_reg && (egt_cnt_reg == EGT_MAX_CYC);
      if (egt_cnt_reg == EGT_MAX_CYC)
        egt_done_reg <= 1'b1;
    end
  end

  // hold-off timer after transmit
  rxc_holdoff u_holdoff (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_start(I_TX_END),
    .i_unit_sel(hold_reg[7]),
    .i_count(hold_reg[6:0]),
    .i_rate(I_TX_RATE),
    .o_ignore(O_RX_IGNORE)
  );

  // disturbance filter; host keeps off the FIFO until three bytes are in
  rxc_emd u_emd (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_en(ctrl_reg[`RXC_B_SUPP]),
    .i_sof(I_RX_SOF),
    .i_byte(I_RX_BYTE),
    .i_err(I_RX_ERR),
    .i_frame_end(I_RX_FRAME_END),
    .o_fifo_flush(O_FIFO_FLUSH),
    .o_rx_done(O_RX_DONE)
  );

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  // register bus: read data stand one cycle, unmapped space answers zero
  read_ctrl_a: assert property (I_RD && I_ADDR == `RXC_ADDR_CTRL
    |=> O_RDATA == $past(ctrl_reg))
    else $error("control read mismatch");
  read_idle_a: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("read data outside answer cycle");
  unmapped_rd_a: assert property (I_RD
    && (I_ADDR < `RXC_ADDR_CTRL || I_ADDR > `RXC_ADDR_ANA) |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  resv_zero_a: assert property (fe_reg[3:2] == 2'h0 && ana_reg[5:4] == 2'h0)
    else $error("reserved bits not zero");

  // front-end fields follow the register flops in the cycle after the write
  fe_write_a: assert property (wr_fe |=> O_AFE.quasi_diff == $past(I_WDATA[7])
    && O_AFE.coll_en == ($past(I_WDATA[1:0]) != 2'h3))
    else $error("front-end write not applied");
  src_route_a: assert property (wr_fe |=> O_AFE.src == $past(I_WDATA[5:4])
    && O_AFE.low_power_card_detect_mode == $past(I_WDATA[6]) && O_AFE.coll_thr == $past(I_WDATA[1:0]))
    else $error("source or converter mode not applied");
  thr_write_a: assert property (wr_thr |=> O_AFE.dec_min == $past(I_WDATA[7:4])
    && O_AFE.phase_min == $past(I_WDATA[3:0]))
    else $error("threshold write not applied");
  ana_write_a: assert property (wr_ana |=> O_AFE.hpcf == $past(I_WDATA[3:2])
    && O_AFE.gain == $past(I_WDATA[1:0]))
    else $error("tuning write not applied");

  // framer settings trail receive_control by one cycle
  stay_on_a: assert property (1'b1 |=> O_FRM.multi == $past(ctrl_reg[`RXC_B_MULTI]))
    else $error("multi-frame flag lost");
  rate_code_a: assert property (wr_ctrl |=> ##1 O_FRM.rate_valid
    == ($past(I_WDATA[2:0], 2) >= 3'h2))
    else $error("rate validity wrong");
  eof_type_a: assert property (wr_ctrl
    |=> ##1 O_FRM.eof_type_b == $past(I_WDATA[5], 2))
    else $error("end type not applied");
  frm_flags_a: assert property (wr_ctrl |=> ##1 O_FRM.suppress == $past(I_WDATA[3], 2)
    && O_FRM.guard_check == $past(I_WDATA[4], 2)
    && O_FRM.allow_partial == $past(I_WDATA[7], 2))
    else $error("framer flags not applied");
  eof_skip_a: assert property (!ctrl_reg[`RXC_B_EOFT] && I_EOF_SYM == 2'h0
    |=> !O_FRM.eof_check_en)
    else $error("end check not skipped");

  // frame end strobes; a blocked partial byte must never slip through
  err_push_a: assert property (I_RX_FRAME_END && ctrl_reg[`RXC_B_MULTI]
    |=> O_ERR_BYTE_PUSH && O_ERR_BYTE == $past(I_ERROR_REG))
    else $error("error byte not appended");
  no_push_a: assert property (I_RX_FRAME_END && !ctrl_reg[`RXC_B_MULTI]
    |=> !O_ERR_BYTE_PUSH)
    else $error("error byte appended outside multi-frame mode");
  partial_wr_a: assert property (I_RX_FRAME_END && I_LAST_PARTIAL
    && ctrl_reg[`RXC_B_ALLOW] |=> O_PARTIAL_WRITE)
    else $error("partial byte not written");
  partial_block_a: assert property (I_RX_FRAME_END && I_LAST_PARTIAL && I_CRC_EN
    && !ctrl_reg[`RXC_B_ALLOW] |=> !O_PARTIAL_WRITE)
    else $error("partial byte written under checksum");

  // guard gap: one error per gap, never without the check
  guard_err_a: assert property (O_PROTOCOL_ERR |-> $past(guard_on, 1))
    else $error("guard error without check");
  guard_fire_a: assert property (guard_on && !egt_done_reg && egt_cnt_reg == EGT_MAX_CYC
    |=> O_PROTOCOL_ERR)
    else $error("guard error missed");
  guard_once_a: assert property (O_PROTOCOL_ERR |=> !O_PROTOCOL_ERR)
    else $error("guard error repeated");

  // hold-off and disturbance outputs of the sub-blocks
  hold_zero_a: assert property (I_TX_END && hold_reg[6:0] == 7'h00
    |=> !O_RX_IGNORE)
    else $error("zero hold-off blanked the receiver");
  flush_done_a: assert property (!(O_FIFO_FLUSH && O_RX_DONE))
    else $error("done raised with a flush");

  // main scenarios worth seeing in a run
  multi_end_c: cover property (I_RX_FRAME_END && ctrl_reg[`RXC_B_MULTI]);
  emd_flush_c: cover property (O_FIFO_FLUSH);
  guard_err_c: cover property (O_PROTOCOL_ERR);
  holdoff_c: cover property ($fell(O_RX_IGNORE));
  emd_done_c: cover property (O_RX_DONE);
endmodule : rxc_regs

/* File: verification/rxc_card.sv */
// behavioural card model that sends start, byte, error and end events to the framer side
module rxc_card (
  // clock
  input wire logic i_clk,
  // framer events
  output logic o_sof,
  output logic o_byte,
  output logic o_err,
  output logic o_end
);
  timeunit 1ns;
  timeprecision 1ps;

  // all event lines idle low until a frame is sent
  initial
  begin
    {o_sof, o_byte, o_err, o_end} = 4'h0;
  end

  // one frame: gap idles before each byte so a slow card can be modelled
  task automatic frame(input int n, input int err_at, input int gap);
    @(posedge i_clk) o_sof <= 1'b1;
    @(posedge i_clk) o_sof <= 1'b0;
    for (int i = 1; i <= n; i++)
    begin
      repeat (gap) @(posedge i_clk);
      o_err <= (i == err_at);
      o_byte <= (i != err_at);
      @(posedge i_clk);
      // back-to-back bytes hold the strobe up instead of dropping and raising it at once
      if (gap > 0 || i == n)
        {o_byte, o_err} <= 2'h0;
    end
    o_end <= 1'b1;
    @(posedge i_clk) o_end <= 1'b0;
  endtask : frame
endmodule : rxc_card

/* File: verification/rxc_regs_test.sv */
// self-checking bench for the receiver configuration bank
`include "rxcfg_params.svh"
module rxc_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, wr_s, rd_s, tx_end, last_partial, crc_en, type_b, extra_guard_time;
  logic [7:0] addr, wdata, err_reg, rdata, err_byte, eb_seen;
  logic [2:0] tx_rate;
  logic [1:0] eof_sym;
  logic sof, byt, err, fend, ign, pw, push, flush, done, perr;
  rxc_pkg::rxc_frm_s frm;
  rxc_pkg::rxc_afe_s afe;
  int n_fail = 0;
  int compares = 0;
  int n_ign, n_pw, n_push, n_fl, n_dn, n_pe;
  // hold-off table: 3 carrier units, 2 half bits at code 6, reserved code, zero count
  logic [7:0] ho_val[4] = '{8'h03, 8'h82, 8'h81, 8'h00};
  logic [2:0] ho_rate[4] = '{3'h0, 3'h6, 3'h0, 3'h7};
  int ho_exp[4] = '{90, 60, 120, 0};
  // disturbance table: early error, short frame, clean frame, short frame unsuppressed
  logic [7:0] sp_ctl[4] = '{8'h0C, 8'h0C, 8'h0C, 8'h04};
  int sp_n[4] = '{4, 2, 4, 2};
  int sp_err[4] = '{2, 0, 0, 0};
  int sp_gap[4] = '{0, 3, 0, 1};
  int sp_fl[4] = '{1, 1, 0, 0};
  int sp_dn[4] = '{0, 0, 1, 1};

  rxc_regs #(.EGT_MAX_CYC(10'h003)) dut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_TX_END(tx_end),
    .I_TX_RATE(tx_rate), .I_RX_SOF(sof), .I_RX_BYTE(byt), .I_RX_ERR(err),
    .I_RX_FRAME_END(fend), .I_LAST_PARTIAL(last_partial), .I_CRC_EN(crc_en),
    .I_ERROR_REG(err_reg), .I_EOF_SYM(eof_sym), .I_TYPE_B(type_b), .I_EGT_ACTIVE(extra_guard_time),
    .O_FRM(frm), .O_AFE(afe), .O_RX_IGNORE(ign), .O_PARTIAL_WRITE(pw),
    .O_ERR_BYTE_PUSH(push), .O_ERR_BYTE(err_byte), .O_FIFO_FLUSH(flush), .O_RX_DONE(done),
    .O_PROTOCOL_ERR(perr));

  rxc_card card (.i_clk(clk), .o_sof(sof), .o_byte(byt), .o_err(err), .o_end(fend));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // pulse counters sample at the falling edge where outputs have settled; unknown never counts
  always @(negedge clk)
  begin
    n_ign += int'(ign === 1'b1);
    n_pw += int'(pw === 1'b1);
    n_push += int'(push === 1'b1);
    n_fl += int'(flush === 1'b1);
    n_dn += int'(done === 1'b1);
    n_pe += int'(perr === 1'b1);
    if (push === 1'b1)
      eb_seen <= err_byte;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk($sformatf("read %h", a), rdata, exp);
  endtask : rd

  // counters are cleared on the rising edge, away from the falling sampling edge
  task automatic clr();
    @(posedge clk);
    {n_ign, n_pw, n_push, n_fl, n_dn, n_pe} = '0;
  endtask : clr

  task automatic close_out();
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // watchdog: the whole sequence needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end

  // main sequence
  initial
  begin
    {rst_n, wr_s, rd_s, tx_end, last_partial, crc_en, type_b, extra_guard_time} = 8'h00;
    {addr, wdata, err_reg, tx_rate, eof_sym} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`RXC_ADDR_CTRL, `RXC_RST_CTRL);
    rd(`RXC_ADDR_HOLD, `RXC_RST_HOLD);
    rd(`RXC_ADDR_FE, `RXC_RST_FE);
    rd(`RXC_ADDR_ANA, `RXC_RST_ANA);
    wr(8'h3A, 8'hFF);
    rd(8'h3A, 8'h00);
    wr(`RXC_ADDR_FE, 8'hFF);
    rd(`RXC_ADDR_FE, 8'hFF & `RXC_FE_WMASK);
    wr(`RXC_ADDR_ANA, 8'h3F);
    rd(`RXC_ADDR_ANA, 8'h0F);
    wr(`RXC_ADDR_THR, 8'hA5);
    rd(`RXC_ADDR_THR, 8'hA5);
    chk("dec_min", afe.dec_min, 4'hA);
    chk("phase_min", afe.phase_min, 4'h5);
    chk("hpcf", afe.hpcf, 2'h3);
    chk("gain", afe.gain, 2'h3);
    // every source and collision code, input mode and converter mode both ways
    for (int k = 0; k < 4; k++)
    begin
      wr(`RXC_ADDR_FE, {k[0], k[1], k[1:0], 2'h0, k[1:0]});
      @(negedge clk);
      chk("quasi_diff", afe.quasi_diff, k[0]);
      chk("low_power_card_detect_mode", afe.low_power_card_detect_mode, k[1]);
      chk("src", afe.src, k[1:0]);
      chk("coll_thr", afe.coll_thr, k[1:0]);
      chk("coll_en", afe.coll_en, k != 3);
    end
    // every rate code
    for (int c = 0; c < 8; c++)
    begin
      wr(`RXC_ADDR_CTRL, {5'h00, c[2:0]});
      repeat (2) @(negedge clk);
      chk("rate", frm.rate, c[2:0]);
      chk("rate_valid", frm.rate_valid, c >= 2);
    end
    // end type against end-symbol config
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk) eof_sym <= {1'b0, k[0]};
      wr(`RXC_ADDR_CTRL, {2'h0, k[1], 5'h04});
      repeat (2) @(negedge clk);
      chk("eof_type_b", frm.eof_type_b, k[1]);
      chk("eof_check_en", frm.eof_check_en, k != 0);
    end
    // hold-off blanking after transmit
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) tx_rate <= ho_rate[i];
      wr(`RXC_ADDR_HOLD, ho_val[i]);
      clr();
      @(posedge clk) tx_end <= 1'b1;
      @(posedge clk) tx_end <= 1'b0;
      repeat (140) @(posedge clk);
      chk("ignore cycles", n_ign, ho_exp[i]);
    end
    // disturbance suppression
    for (int i = 0; i < 4; i++)
    begin
      wr(`RXC_ADDR_CTRL, sp_ctl[i]);
      clr();
      card.frame(sp_n[i], sp_err[i], sp_gap[i]);
      repeat (3) @(posedge clk);
      chk("flush count", n_fl, sp_fl[i]);
      chk("done count", n_dn, sp_dn[i]);
      chk("suppress", frm.suppress, sp_ctl[i][3]);
    end
    // multi-frame appends the error register copy
    @(posedge clk) err_reg <= 8'h5A;
    wr(`RXC_ADDR_CTRL, 8'h44);
    clr();
    card.frame(1, 0, 0);
    repeat (3) @(posedge clk);
    chk("push count", n_push, 1);
    chk("error byte", eb_seen, 8'h5A);
    chk("multi", frm.multi, 1'b1);
    // incomplete last byte with checksum on
    @(posedge clk) {last_partial, crc_en} <= 2'h3;
    for (int k = 0; k < 2; k++)
    begin
      wr(`RXC_ADDR_CTRL, k ? 8'h84 : 8'h04);
      clr();
      card.frame(1, 0, 0);
      repeat (3) @(posedge clk);
      chk("partial write", n_pw, k);
      chk("allow_partial", frm.allow_partial, k);
    end
    // guard gap longer than the limit, check off and on
    @(posedge clk) type_b <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wr(`RXC_ADDR_CTRL, k ? 8'h14 : 8'h04);
      clr();
      @(posedge clk) extra_guard_time <= 1'b1;
      repeat (10) @(posedge clk);
      extra_guard_time <= 1'b0;
      repeat (2) @(posedge clk);
      chk("protocol error", n_pe, k);
      chk("guard_check", frm.guard_check, k);
    end
    close_out();
  end
endmodule : rxc_regs_test
